// >>> dbp_pin_mux.sv
// drop bus payload indicator / general purpose pin mux with byte fifo
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// byte fifo with registered full and empty flags
// ----------------------------------------------------------------
module dbp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = dbp_pkg::FIFO_DEPTH
) (
	input wire logic clk, // system clock
	input wire logic srst, // sync reset, high
	input wire logic [WIDTH-1:0] inData, // word to store
	input wire logic inValid, // word offered
	output logic inReady, // room for a word
	output logic [WIDTH-1:0] outData, // oldest word
	output logic outValid, // oldest word present
	input wire logic outReady // drain side takes word
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic full_q;
	logic room_q;
	logic empty_q;
	logic push;
	logic pop;

	// flags come from flops so that the ready seen outside is clean
	assign push = inValid && !full_q;
	assign pop = outReady && !empty_q;
	assign inReady = room_q;
	assign outValid = !empty_q;
	assign outData = mem[rdPtr_q];

	// occupancy after this edge
	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// storage, no reset needed on the array
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	// pointers wrap naturally, depth must be a power of two
	always_ff @(posedge clk) begin
		if (srst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end

	// count and flags
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= '0;
			full_q <= 1'b0;
			room_q <= 1'b1;
			empty_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			full_q <= (cnt_d == (AW+1)'(DEPTH));
			room_q <= (cnt_d != (AW+1)'(DEPTH));
			empty_q <= (cnt_d == '0);
		end
	end

	chk_fifo_no_over: assert property (@(posedge clk) disable iff (srst)
		inValid && full_q && !outReady |=> full_q && $stable(wrPtr_q))
		else $error("fifo took a word while full");

endmodule // dbp_fifo

module dbp_pin_mux #(
	parameter int DEPTH = dbp_pkg::FIFO_DEPTH
) (
	input wire logic clk, // bus clock, rising edge
	input wire logic srst, // sync reset, high
	input wire logic [15:0] regAddr, // register byte address
	input wire logic [7:0] regWdata, // register write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic [7:0] regRdata, // read data, cycle after strobe
	input wire dbp_pkg::dbp_byte_t inByte [3], // bytes from framer
	input wire logic [2:0] inValid, // byte offered per channel
	output logic [2:0] inReady, // fifo room per channel
	input wire logic [2:0] outReady, // downstream takes byte
	output logic [2:0] dropValid, // byte present on drop data
	output logic [7:0] dropDataCh1, // drop data, channel 1
	output logic [7:0] dropDataCh2, // drop data, channel 2
	output logic [7:0] dropDataCh3, // drop data, channel 3
	output logic dropPayloadFlagCh1, // shared pin, channel 1
	output logic dropPayloadFlagCh2, // shared pin, channel 2
	output logic dropPayloadFlagCh3 // shared pin, channel 3
);

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	logic [7:0] lineDrive_q [3];
	logic [2:0] tbEnable_q;
	logic [7:0] regRdata_q;
	logic [7:0] dropData_q [3];
	logic [2:0] dropValid_q;
	logic [2:0] pin_q;
	logic [2:0] fifoReady;
	logic [2:0] fifoValid;
	logic [2:0] take;
	dbp_pkg::dbp_byte_t fifoByte [3];
	dbp_pkg::dbp_pin_mode_t mode [3];

	// map a byte address onto a line drive channel, CH_NONE if none
	function automatic logic [1:0] chanOf(input logic [15:0] a);
		logic [1:0] c;
		c = dbp_pkg::CH_NONE;
		if (a == dbp_pkg::LINE_DRIVE_CH1_OFS) begin
			c = 2'h0;
		end else if (a == dbp_pkg::LINE_DRIVE_CH2_OFS) begin
			c = 2'h1;
		end else if (a == dbp_pkg::LINE_DRIVE_CH3_OFS) begin
			c = 2'h2;
		end
		return c;
	endfunction

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------

	// line drive registers, bit 4 is the pin level in gpo mode
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < 3; i++) begin
				lineDrive_q[i] <= dbp_pkg::LINE_DRIVE_RST;
			end
		end else if (regWr && chanOf(regAddr) != dbp_pkg::CH_NONE) begin
			lineDrive_q[chanOf(regAddr)] <= regWdata;
		end
	end

	// telecom bus interface enables, one bit per channel
	always_ff @(posedge clk) begin
		if (srst) begin
			tbEnable_q <= dbp_pkg::TB_ENABLE_RST;
		end else if (regWr && regAddr == dbp_pkg::TB_ENABLE_OFS) begin
			tbEnable_q <= regWdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------

	// data stand one cycle only; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (srst || !regRd) begin
			regRdata_q <= 8'h00;
		end else if (chanOf(regAddr) != dbp_pkg::CH_NONE) begin
			regRdata_q <= lineDrive_q[chanOf(regAddr)];
		end else if (regAddr == dbp_pkg::TB_ENABLE_OFS) begin
			regRdata_q <= {5'h00, tbEnable_q};
		end else if (regAddr == dbp_pkg::PIN_STATUS_OFS) begin
			regRdata_q <= {2'h0, fifoValid, pin_q};
		end else begin
			regRdata_q <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// per channel data path and pin
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < 3; ch++) begin : g_ch

		dbp_fifo #(
			.WIDTH($bits(dbp_pkg::dbp_byte_t)),
			.DEPTH(DEPTH)
		) u_fifo (
			.clk(clk),
			.srst(srst),
			.inData(inByte[ch]),
			.inValid(inValid[ch]),
			.inReady(fifoReady[ch]),
			.outData(fifoByte[ch]),
			.outValid(fifoValid[ch]),
			.outReady(outReady[ch])
		);

		// a byte leaves the fifo when downstream is ready
		assign take[ch] = fifoValid[ch] && outReady[ch];

		// pin function from the interface enable
		assign mode[ch] = tbEnable_q[ch] ? dbp_pkg::PIN_PAYLOAD :
			dbp_pkg::PIN_GPO;

		// data stage, loaded on the same edge as the pin
		always_ff @(posedge clk) begin
			if (srst) begin
				dropData_q[ch] <= 8'h00;
				dropValid_q[ch] <= 1'b0;
			end else begin
				dropValid_q[ch] <= take[ch];
				if (take[ch]) begin
					dropData_q[ch] <= fifoByte[ch].data;
				end
			end
		end

		// pin mux; idle clocks carry no overhead, so read high
		always_ff @(posedge clk) begin
			if (srst) begin
				pin_q[ch] <= dbp_pkg::PIN_RST;
			end else begin
				case (mode[ch])
					dbp_pkg::PIN_PAYLOAD: begin
						if (take[ch]) begin
							pin_q[ch] <= !fifoByte[ch].toh;
						end else begin
							pin_q[ch] <= 1'b1;
						end
					end
					dbp_pkg::PIN_GPO: begin
						pin_q[ch] <=
							lineDrive_q[ch][dbp_pkg::GP_OUT_LEVEL_BIT];
					end
					default: begin
						pin_q[ch] <= dbp_pkg::PIN_RST;
					end
				endcase
			end
		end

		// a byte taken in payload mode, with its overhead marker
		sequence seqTake(logic isToh);
			tbEnable_q[ch] && take[ch] && fifoByte[ch].toh == isToh;
		endsequence

		chk_toh_pin_low: assert property (
			@(posedge clk) disable iff (srst)
			seqTake(1'b1) |=> !pin_q[ch] && dropValid_q[ch])
			else $error("pin not low on overhead byte");

		chk_payload_pin_high: assert property (
			@(posedge clk) disable iff (srst)
			seqTake(1'b0) |=> pin_q[ch] && dropValid_q[ch])
			else $error("pin not high on non overhead byte");

		chk_idle_pin_high: assert property (
			@(posedge clk) disable iff (srst)
			tbEnable_q[ch] && !take[ch] |=> pin_q[ch] && !dropValid_q[ch])
			else $error("pin not high in idle payload clock");

		chk_gpo_follows_bit: assert property (
			@(posedge clk) disable iff (srst)
			!tbEnable_q[ch] |=>
			pin_q[ch] == $past(lineDrive_q[ch][dbp_pkg::GP_OUT_LEVEL_BIT]))
			else $error("gpo pin does not follow drive bit");

		chk_data_aligned: assert property (
			@(posedge clk) disable iff (srst)
			take[ch] |=> dropValid_q[ch] &&
			dropData_q[ch] == $past(fifoByte[ch].data))
			else $error("drop data not aligned with pin");
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign regRdata = regRdata_q;
	assign inReady = fifoReady;
	assign dropValid = dropValid_q;
	assign dropDataCh1 = dropData_q[0];
	assign dropDataCh2 = dropData_q[1];
	assign dropDataCh3 = dropData_q[2];
	assign dropPayloadFlagCh1 = pin_q[0];
	assign dropPayloadFlagCh2 = pin_q[1];
	assign dropPayloadFlagCh3 = pin_q[2];

	// ----------------------------------------------------------------
	// register to pin checks
	// ----------------------------------------------------------------

	// a drive write while gpo mode holds for two clocks
	sequence seqDriveWr(logic [15:0] ofs, logic en);
		(regWr && regAddr == ofs && !en) ##1 !en;
	endsequence

	chk_ch1_drive_pin: assert property (
		@(posedge clk) disable iff (srst)
		seqDriveWr(dbp_pkg::LINE_DRIVE_CH1_OFS, tbEnable_q[0]) |=>
		pin_q[0] == $past(regWdata[dbp_pkg::GP_OUT_LEVEL_BIT], 2))
		else $error("channel 1 pin misses drive bit");

	chk_ch2_drive_pin: assert property (
		@(posedge clk) disable iff (srst)
		seqDriveWr(dbp_pkg::LINE_DRIVE_CH2_OFS, tbEnable_q[1]) |=>
		pin_q[1] == $past(regWdata[dbp_pkg::GP_OUT_LEVEL_BIT], 2))
		else $error("channel 2 pin misses drive bit");

	chk_ch3_drive_pin: assert property (
		@(posedge clk) disable iff (srst)
		seqDriveWr(dbp_pkg::LINE_DRIVE_CH3_OFS, tbEnable_q[2]) |=>
		pin_q[2] == $past(regWdata[dbp_pkg::GP_OUT_LEVEL_BIT], 2))
		else $error("channel 3 pin misses drive bit");

	chk_read_one_cycle: assert property (
		@(posedge clk) disable iff (srst)
		!regRd |=> regRdata_q == 8'h00)
		else $error("read data outside answer cycle");

endmodule // dbp_pin_mux
`default_nettype wire

// >>> dbp_pkg.sv
// constants and types shared by the drop bus payload indicator mux
`default_nettype none
package dbp_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int NUM_CH = 3;
	localparam int FIFO_DEPTH = 8;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [15:0] LINE_DRIVE_CH1_OFS = 16'h2F80;
	localparam logic [15:0] LINE_DRIVE_CH2_OFS = 16'h3F80;
	localparam logic [15:0] LINE_DRIVE_CH3_OFS = 16'h4F80;
	localparam logic [15:0] TB_ENABLE_OFS = 16'h0010;
	localparam logic [15:0] PIN_STATUS_OFS = 16'h0014;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int GP_OUT_LEVEL_BIT = 4;
	localparam int STAT_PIN_POS = 0;
	localparam int STAT_FIFO_POS = 3;
	localparam logic [7:0] LINE_DRIVE_RST = 8'h00;
	localparam logic [2:0] TB_ENABLE_RST = 3'h0;
	localparam logic PIN_RST = 1'b0;
	localparam logic [1:0] CH_NONE = 2'h3;

	// ----------------------------------------------------------------
	// clocking of the drop bus
	// ----------------------------------------------------------------
	localparam real CLK_MHZ = 40.0;
	localparam real DROP_CLK_MHZ = 19.44;

	// one byte on the drop bus with its overhead marker
	typedef struct packed {
		logic toh;
		logic [7:0] data;
	} dbp_byte_t;

	// function of each shared pin
	typedef enum logic [1:0] {
		PIN_GPO = 2'b01,
		PIN_PAYLOAD = 2'b10
	} dbp_pin_mode_t;

endpackage
`default_nettype wire

// >>> dbp_drop_sink.sv
// downstream drop bus receiver model, one channel
`timescale 1ns/100ps
`default_nettype none
module dbp_drop_sink (
	input wire logic clk, // drop bus clock
	input wire logic srst, // sync reset, high
	input wire logic stall, // hold off every byte
	input wire logic slow, // accept every other cycle
	input wire logic dropValid, // byte on drop data
	input wire logic [7:0] dropData, // drop data
	input wire logic dropPayloadFlag, // shared pin
	output logic outReady, // ready toward the block
	output logic [4:0] cnt, // bytes seen, wraps
	output logic [8:0] lastWord // pin and byte of last one
);
	// ready moves only after an edge, as a real receiver would
	always_ff @(posedge clk) begin
		if (srst) begin
			outReady <= 1'b0;
		end else begin
			outReady <= !stall && (!slow || !outReady);
		end
	end
	// pin taken on the same edge as its byte, so skew shows up
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt <= 5'h00;
			lastWord <= 9'h000;
		end else if (dropValid) begin
			cnt <= cnt + 5'h01;
			lastWord <= {dropPayloadFlag, dropData};
		end
	end
endmodule // dbp_drop_sink
`default_nettype wire

// >>> dbp_pin_mux_tb.sv
// self-checking bench for the drop bus pin mux
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errors++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module dbp_pin_mux_tb;
	// ----------------------------------------------------------------
	// signals and table
	// ----------------------------------------------------------------
	typedef struct packed {
		logic en;
		logic [7:0] drv;
		logic toh;
		logic [7:0] data;
		logic pin;
	} dbp_row_t;
	localparam dbp_row_t ROWS [4] = '{'{1'b1, 8'h00, 1'b1, 8'hA5, 1'b0},
		'{1'b1, 8'h10, 1'b0, 8'h3C, 1'b1}, '{1'b0, 8'h10, 1'b1, 8'h5A, 1'b1},
		'{1'b0, 8'hEF, 1'b0, 8'hC3, 1'b0}};
	logic [15:0] drvOfs [3] = '{dbp_pkg::LINE_DRIVE_CH1_OFS,
		dbp_pkg::LINE_DRIVE_CH2_OFS, dbp_pkg::LINE_DRIVE_CH3_OFS};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [15:0] regAddr = 16'h0000;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdata;
	dbp_pkg::dbp_byte_t inByte [3] = '{default: 9'h000};
	logic [2:0] inValid = 3'h0;
	logic [2:0] inReady;
	logic [2:0] stall = 3'h0;
	logic [2:0] slow = 3'h0;
	wire logic [2:0] outReady;
	wire logic [2:0] dropValid;
	wire logic [2:0] pin;
	wire logic [7:0] dropData [3];
	wire logic [4:0] cnt [3];
	wire logic [8:0] lastWord [3];
	logic [4:0] seenCnt [3] = '{default: 5'h00};
	logic [7:0] rv;
	logic [8:0] w;
	int errors = 0;
	int nChecks = 0;

	dbp_pin_mux dut (.clk(clk), .srst(srst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.inByte(inByte), .inValid(inValid), .inReady(inReady),
		.outReady(outReady), .dropValid(dropValid), .dropDataCh1(dropData[0]),
		.dropDataCh2(dropData[1]), .dropDataCh3(dropData[2]),
		.dropPayloadFlagCh1(pin[0]), .dropPayloadFlagCh2(pin[1]),
		.dropPayloadFlagCh3(pin[2]));
	// one receiver model per channel
	for (genvar i = 0; i < 3; i++) begin : gSink
		dbp_drop_sink sink (.clk(clk), .srst(srst), .stall(stall[i]),
			.slow(slow[i]), .dropValid(dropValid[i]), .dropData(dropData[i]),
			.dropPayloadFlag(pin[i]), .outReady(outReady[i]), .cnt(cnt[i]),
			.lastWord(lastWord[i]));
	end

	// ----------------------------------------------------------------
	// bus and stream tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	task automatic push(input int ch, input logic t, input logic [7:0] d);
		@(posedge clk);
		inByte[ch] <= '{toh: t, data: d};
		inValid[ch] <= 1'b1;
		@(posedge clk);
		inValid[ch] <= 1'b0;
	endtask
	// bounded wait for the next byte seen by the receiver model
	task automatic takeByte(input int ch, output logic [8:0] o);
		int k;
		for (k = 0; k < 40 && cnt[ch] === seenCnt[ch]; k++) begin
			@(posedge clk);
			#1;
		end
		`CHK(cnt[ch], seenCnt[ch] + 5'h01)
		seenCnt[ch] = seenCnt[ch] + 5'h01;
		o = lastWord[ch];
	endtask
	task automatic giveVerdict;
		$display("checks %0d mismatches %0d", nChecks, errors);
		if (errors == 0 && nChecks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------------------------------
	initial begin
		forever #12.5 clk = ~clk;
	end
	// all tests need well under two thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		giveVerdict();
	end
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		// every channel through both pin functions
		for (int ch = 0; ch < 3; ch++) begin
			for (int r = 0; r < 4; r++) begin
				wr(dbp_pkg::TB_ENABLE_OFS, 8'(ROWS[r].en) << ch);
				wr(drvOfs[ch], ROWS[r].drv);
				push(ch, ROWS[r].toh, ROWS[r].data);
				takeByte(ch, w);
				`CHK(w, {ROWS[r].pin, ROWS[r].data})
				rd(drvOfs[ch], rv);
				`CHK(rv, ROWS[r].drv)
			end
		end
		$display("table test done");
		// second reset in mid-run, then reset values and an unmapped read
		@(posedge clk);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		seenCnt = '{default: 5'h00};
		for (int ch = 0; ch < 3; ch++) begin
			rd(drvOfs[ch], rv);
			`CHK(rv, dbp_pkg::LINE_DRIVE_RST)
		end
		rd(dbp_pkg::TB_ENABLE_OFS, rv);
		`CHK(rv, 8'h00)
		rd(16'h1234, rv);
		`CHK(rv, 8'h00)
		`CHK(pin, 3'h0)
		$display("reset test done");
		// idle payload cycles leave every pin high
		stall[0] <= 1'b1;
		wr(dbp_pkg::TB_ENABLE_OFS, 8'h07);
		repeat (3) @(posedge clk);
		#1 `CHK(pin, 3'h7)
		// fill channel 1 while its receiver stalls, then refuse one more
		@(posedge clk);
		inValid[0] <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			inByte[0] <= '{toh: i[0], data: 8'(i) + 8'h40};
			@(posedge clk);
		end
		inByte[0] <= '{toh: 1'b1, data: 8'hFF};
		repeat (3) @(posedge clk);
		inValid[0] <= 1'b0;
		#1 `CHK(inReady[0], 1'b0)
		rd(dbp_pkg::PIN_STATUS_OFS, rv);
		`CHK(rv[dbp_pkg::STAT_FIFO_POS], 1'b1)
		`CHK(rv[2:0], 3'h7)
		// drain against a slow receiver, bytes in order, pin per byte
		@(posedge clk);
		slow[0] <= 1'b1;
		stall[0] <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			takeByte(0, w);
			`CHK(w, {!i[0], 8'(i) + 8'h40})
		end
		repeat (10) @(posedge clk);
		#1 `CHK(cnt[0], seenCnt[0])
		`CHK(inReady[0], 1'b1)
		$display("fifo test done");
		giveVerdict();
	end
endmodule // dbp_pin_mux_tb
`undef CHK
`default_nettype wire
